// File: common/svc_pkg.sv
package svc_pkg;
   localparam logic [7:0] SVC_REG_MAX_CODE = 8'h30;
   localparam logic [7:0] SVC_CODE_OFF = 8'h00;
   localparam logic [7:0] SVC_CODE_HOLE_LO = 8'h01;
   localparam logic [7:0] SVC_CODE_HOLE_HI = 8'h32;
   localparam logic [7:0] SVC_CODE_MAX_RST = 8'hFF;
   localparam logic [3:0] SVC_ADDR_MAIN = 4'h0;
   localparam logic [3:0] SVC_ADDR_MEM0 = 4'h2;
   localparam logic [3:0] SVC_ADDR_MEM1 = 4'h4;
   localparam int SVC_NUM_RAILS = 3;
   localparam int SVC_FAST_MV_PER_US = 20;
   localparam int SVC_SLOW_MV_PER_US = 5;

   typedef enum logic [2:0] {
      SVC_OP_FAST = 3'h0,
      SVC_OP_SLOW = 3'h1,
      SVC_OP_DECAY = 3'h2,
      SVC_OP_PSTATE = 3'h3,
      SVC_OP_SETREG = 3'h4
   } svc_op_e;

   typedef enum logic [7:0] {
      SVC_PS_FULL = 8'h00,
      SVC_PS_LIGHT = 8'h01,
      SVC_PS_VLIGHT = 8'h02
   } svc_ps_e;

   typedef struct packed {
      svc_op_e op;
      logic [3:0] addr;
      logic [7:0] payload;
   } svc_cmd_s;

   typedef enum logic [1:0] {
      SVC_ST_IDLE = 2'b10,
      SVC_ST_INIT = 2'b01,
      SVC_ST_WAIT = 2'b11
   } svc_state_e;
endpackage

// File: hdl/svc_code_clamp.sv
`timescale 1ns/10ps
module svc_code_clamp
   import svc_pkg::*;
(
   input wire logic [7:0] i_code,
   input wire logic [7:0] i_max,
   output logic [7:0] o_code,
   output logic o_changed
);
   logic [7:0] lim;
   always_comb begin
      lim = i_code;
      if (lim > i_max) begin
         lim = i_max;
      end
      // Codes in the hole are pushed to the lowest legal code, or to off if that is above i_max
      if (lim >= SVC_CODE_HOLE_LO && lim <= SVC_CODE_HOLE_HI) begin
         lim = SVC_CODE_HOLE_HI + 8'h01;
      end
      if (lim > i_max) begin
         lim = SVC_CODE_OFF;
      end
      o_code = lim;
      o_changed = (lim != i_code);
   end
endmodule

// File: hdl/svc_ctrl.sv
`timescale 1ns/10ps
module svc_ctrl
   import svc_pkg::*;
#(
   parameter logic [7:0] MAX_CODE = SVC_CODE_MAX_RST
)
(
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_req_valid,
   input wire logic [1:0] i_req_rail,
   input wire logic [7:0] i_req_code,
   input wire logic i_req_step_slow,
   input wire logic i_deep_idle,
   input wire logic i_low_current,
   input wire logic i_very_low_current,
   input wire logic i_bus_ready,
   output logic o_req_ready,
   output logic o_cmd_valid,
   output svc_cmd_s o_cmd,
   output logic o_init_done,
   output logic o_code_clamped
);
   svc_state_e state_q, state_d;
   svc_cmd_s cmd_q, cmd_d;
   logic valid_q, valid_d;
   logic idle_q, idle_d;
   logic ps_pend_q, ps_pend_d;
   logic [3:0] ps_addr_q, ps_addr_d;
   logic clamp_q, clamp_d;
   logic [7:0] cur_q [SVC_NUM_RAILS];
   logic [7:0] cur_d [SVC_NUM_RAILS];
   logic [7:0] safe_code;
   logic changed;
   logic [3:0] rail_addr;
   logic fire;

   svc_code_clamp u_clamp (
      .i_code(i_req_code),
      .i_max(MAX_CODE),
      .o_code(safe_code),
      .o_changed(changed)
   );

   always_comb begin
      unique case (i_req_rail)
         2'd1: rail_addr = SVC_ADDR_MEM0;
         2'd2: rail_addr = SVC_ADDR_MEM1;
         default: rail_addr = SVC_ADDR_MAIN;
      endcase
   end

   // Command slot frees while the bus takes it, so requests stall no longer, except while ps_pend_q is set after an upward ramp
   assign fire = valid_q && i_bus_ready;
   assign o_req_ready = (state_q == SVC_ST_IDLE) && (!valid_q || fire)
      && !ps_pend_q;

   always_comb begin
      state_d = state_q;
      cmd_d = cmd_q;
      valid_d = valid_q && !i_bus_ready;
      idle_d = i_deep_idle;
      ps_pend_d = ps_pend_q;
      ps_addr_d = ps_addr_q;
      clamp_d = clamp_q;
      for (int r = 0; r < SVC_NUM_RAILS; r++) begin
         cur_d[r] = cur_q[r];
      end
      unique case (state_q)
         SVC_ST_INIT: begin
            cmd_d.op = SVC_OP_SETREG;
            cmd_d.addr = SVC_ADDR_MAIN;
            cmd_d.payload = MAX_CODE;
            valid_d = 1'b1;
            state_d = SVC_ST_WAIT;
         end
         SVC_ST_WAIT: begin
            if (fire) begin
               state_d = SVC_ST_IDLE;
            end
         end
         SVC_ST_IDLE: begin
            if (!valid_q || fire) begin
               if (ps_pend_q) begin
                  // Regulator left low power on the upward ramp
                  cmd_d.op = SVC_OP_PSTATE;
                  cmd_d.addr = ps_addr_q;
                  cmd_d.payload = i_very_low_current ? SVC_PS_VLIGHT
                     : SVC_PS_LIGHT;
                  valid_d = i_low_current || i_very_low_current;
                  ps_pend_d = 1'b0;
               end else if (i_deep_idle && !idle_q) begin
                  cmd_d.op = SVC_OP_DECAY;
                  cmd_d.addr = SVC_ADDR_MAIN;
                  cmd_d.payload = SVC_CODE_HOLE_HI + 8'h01;
                  valid_d = 1'b1;
               end else if (!i_deep_idle && idle_q) begin
                  cmd_d.op = SVC_OP_FAST;
                  cmd_d.addr = SVC_ADDR_MAIN;
                  cmd_d.payload = cur_q[0];
                  valid_d = 1'b1;
               end else if (i_req_valid) begin
                  // Each request is one step; a target may take several
                  cmd_d.op = (safe_code < cur_q[i_req_rail]) && !i_req_step_slow
                     ? SVC_OP_DECAY
                     : (i_req_step_slow ? SVC_OP_SLOW : SVC_OP_FAST);
                  cmd_d.addr = rail_addr;
                  cmd_d.payload = safe_code;
                  valid_d = 1'b1;
                  clamp_d = changed;
                  cur_d[i_req_rail] = safe_code;
                  if (safe_code > cur_q[i_req_rail]) begin
                     ps_pend_d = 1'b1;
                     ps_addr_d = rail_addr;
                  end
               end
            end
         end
         default: state_d = SVC_ST_INIT;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= SVC_ST_INIT;
         cmd_q <= '0;
         valid_q <= 1'b0;
         idle_q <= 1'b0;
         ps_pend_q <= 1'b0;
         ps_addr_q <= 4'h0;
         clamp_q <= 1'b0;
         for (int r = 0; r < SVC_NUM_RAILS; r++) begin
            cur_q[r] <= SVC_CODE_OFF;
         end
      end else begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         valid_q <= valid_d;
         idle_q <= idle_d;
         ps_pend_q <= ps_pend_d;
         ps_addr_q <= ps_addr_d;
         clamp_q <= clamp_d;
         for (int r = 0; r < SVC_NUM_RAILS; r++) begin
            cur_q[r] <= cur_d[r];
         end
      end
   end

   assign o_cmd_valid = valid_q;
   assign o_cmd = cmd_q;
   assign o_init_done = (state_q == SVC_ST_IDLE);
   assign o_code_clamped = clamp_q;

   logic ramp_cmd;
   assign ramp_cmd = valid_q && (cmd_q.op != SVC_OP_PSTATE)
      && (cmd_q.op != SVC_OP_SETREG);

   a_max_code: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      ramp_cmd |-> cmd_q.payload <= MAX_CODE)
      else $error("ramp code above maximum");

   a_code_hole: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      ramp_cmd |-> !(cmd_q.payload >= 8'h01 && cmd_q.payload <= 8'h32))
      else $error("ramp code in unused range");

   a_first_cmd: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      $rose(o_init_done) |-> $past(cmd_q.op) == SVC_OP_SETREG
         && $past(cmd_q.payload) == MAX_CODE)
      else $error("maximum code not written first");

   a_addr_legal: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      valid_q |-> cmd_q.addr inside {4'h0, 4'h2, 4'h4})
      else $error("bad rail address");

   a_idle_entry: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      $rose(i_deep_idle) && o_init_done && !ps_pend_q && (!valid_q || fire)
      |=> valid_q && cmd_q.op == SVC_OP_DECAY)
      else $error("no decay on deep idle entry");

   a_idle_exit: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      $fell(i_deep_idle) && o_init_done && !ps_pend_q && (!valid_q || fire)
      |=> valid_q && cmd_q.op == SVC_OP_FAST)
      else $error("no fast ramp on deep idle exit");

   a_ps_payload: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      valid_q && cmd_q.op == SVC_OP_PSTATE |-> cmd_q.payload <= 8'h02)
      else $error("bad power state code");

   a_cmd_hold: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      valid_q && !i_bus_ready |=> valid_q && $stable(cmd_q))
      else $error("command changed while stalled");

   a_ps_resend: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      ps_pend_q && (!valid_q || fire) && i_low_current
      |=> valid_q && cmd_q.op == SVC_OP_PSTATE)
      else $error("low power state not resent");
endmodule

// File: test/svc_vr_model.sv
`timescale 1ns/10ps
module svc_vr_model
   import svc_pkg::*;
#(
   parameter logic [7:0] CAP_CODE = 8'hFF
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_slow,
   input wire logic i_socket_occupied_n,
   input wire logic i_cmd_valid,
   input wire svc_cmd_s i_cmd,
   output logic o_bus_ready
);
   svc_cmd_s log[$];
   logic [7:0] code_q [0:15];
   logic [7:0] ps_q;
   logic nak_q;
   logic on_q;
   logic [1:0] cnt_q;
   // Slow mode is ready one cycle in four, so the stall path is exercised
   assign o_bus_ready = i_slow ? (cnt_q == 2'h3) : 1'b1;
   assign on_q = !i_socket_occupied_n && !nak_q;
   // Ramp rates and load levels are not modelled, only target codes
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= 2'h0;
         nak_q <= 1'b0;
         ps_q <= SVC_PS_FULL;
         for (int i = 0; i < 16; i++) code_q[i] <= 8'h00;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         if (i_cmd_valid && o_bus_ready) begin
            log.push_back(i_cmd);
            case (i_cmd.op)
               SVC_OP_SETREG: nak_q <= i_cmd.payload > CAP_CODE;
               // Phases or pulse skipping stay abstract
               SVC_OP_PSTATE: ps_q <= (i_cmd.payload > 8'h02) ? 8'h02 :
                  i_cmd.payload;
               default: begin
                  if (i_cmd.payload > code_q[i_cmd.addr]) begin
                     ps_q <= SVC_PS_FULL;
                  end
                  // Any ramp preempts the last
                  code_q[i_cmd.addr] <= i_cmd.payload;
               end
            endcase
         end
      end
   end
endmodule

// File: test/testbench.sv
`timescale 1ns/10ps
module testbench;
   import svc_pkg::*;
   localparam logic [7:0] MAXC = 8'hC0;
   logic clk, rst_n, valid, slow, idle, low, vlow, vr_slow;
   logic bus_ready, ready, cmd_valid, init_done, clamped;
   logic [1:0] rail;
   logic [7:0] code;
   svc_cmd_s cmd, got;
   int err_count, cmp_count, cycles;
   svc_ctrl #(.MAX_CODE(MAXC)) u_dut(.i_ref_clk(clk), .i_reset_n(rst_n),
      .i_req_valid(valid), .i_req_rail(rail), .i_req_code(code),
      .i_req_step_slow(slow), .i_deep_idle(idle), .i_low_current(low),
      .i_very_low_current(vlow), .i_bus_ready(bus_ready),
      .o_req_ready(ready), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
      .o_init_done(init_done), .o_code_clamped(clamped));
   svc_vr_model u_vr(.i_clk(clk), .i_rst_n(rst_n), .i_slow(vr_slow),
      .i_socket_occupied_n(1'b0), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
      .o_bus_ready(bus_ready));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [14:0] g, input logic [14:0] e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic req(input logic [1:0] r, input logic [7:0] c,
                      input logic s);
      @(posedge clk);
      valid <= 1'b1;
      rail <= r;
      code <= c;
      slow <= s;
      do @(negedge clk); while (ready !== 1'b1);
      @(posedge clk);
      valid <= 1'b0;
   endtask
   // Addresses are left unchecked when ca is clear, as for the setup command
   task automatic exp(input svc_op_e op, input logic [3:0] a,
                      input logic [7:0] p, input bit ca);
      repeat (60) if (u_vr.log.size() == 0) @(negedge clk);
      got = (u_vr.log.size() > 0) ? u_vr.log.pop_front() : '1;
      chk(ca ? got : {got.op, 4'h0, got.payload}, {op, a, p});
      // Hand back on a rising edge so the next stimulus lands there
      @(posedge clk);
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles > 3000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      {rst_n, valid, slow, idle, low, vlow, vr_slow, rail} = '0;
      code = 8'h00;
      repeat (8) @(posedge clk);
      chk({ready, cmd_valid, init_done}, 15'h0);
      rst_n <= 1'b1;
      exp(SVC_OP_SETREG, 4'h0, MAXC, 0);
      @(negedge clk);
      chk(15'(init_done), 15'h1);
      chk(15'(u_vr.on_q), 15'h1);
      $display("test setup done");
      req(2'h0, 8'h80, 1'b0);
      exp(SVC_OP_FAST, SVC_ADDR_MAIN, 8'h80, 1);
      repeat (10) @(posedge clk);
      chk(15'(u_vr.log.size()), 15'h0);
      low <= 1'b1;
      req(2'h1, 8'h40, 1'b0);
      exp(SVC_OP_FAST, SVC_ADDR_MEM0, 8'h40, 1);
      exp(SVC_OP_PSTATE, SVC_ADDR_MEM0, SVC_PS_LIGHT, 1);
      low <= 1'b0;
      vlow <= 1'b1;
      req(2'h2, 8'h50, 1'b0);
      exp(SVC_OP_FAST, SVC_ADDR_MEM1, 8'h50, 1);
      exp(SVC_OP_PSTATE, SVC_ADDR_MEM1, SVC_PS_VLIGHT, 1);
      vlow <= 1'b0;
      $display("test fast ramps done");
      vr_slow <= 1'b1;
      req(2'h1, 8'h38, 1'b1);
      req(2'h0, 8'h60, 1'b0);
      exp(SVC_OP_SLOW, SVC_ADDR_MEM0, 8'h38, 1);
      exp(SVC_OP_DECAY, SVC_ADDR_MAIN, 8'h60, 1);
      vr_slow <= 1'b0;
      $display("test slow and decay done");
      req(2'h2, 8'hE0, 1'b1);
      exp(SVC_OP_SLOW, SVC_ADDR_MEM1, MAXC, 1);
      chk(15'(clamped), 15'h1);
      req(2'h2, 8'h10, 1'b1);
      exp(SVC_OP_SLOW, SVC_ADDR_MEM1, 8'h33, 1);
      req(2'h2, 8'h38, 1'b1);
      exp(SVC_OP_SLOW, SVC_ADDR_MEM1, 8'h38, 1);
      chk(15'(clamped), 15'h0);
      $display("test clamp done");
      repeat (4) @(posedge clk);
      idle <= 1'b1;
      exp(SVC_OP_DECAY, SVC_ADDR_MAIN, 8'h33, 1);
      repeat (4) @(posedge clk);
      idle <= 1'b0;
      exp(SVC_OP_FAST, SVC_ADDR_MAIN, 8'h60, 1);
      $display("test deep idle done");
      wrap_up();
   end
endmodule
